/* core/eied_pkg.sv */
// constants, types and helpers shared by the edge-detect block
package eied_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS = 10;
   localparam int TCL_NS = 10;
   localparam int FAST_SAMPLE_TCL = 2;
   localparam int STD_SAMPLE_TCL = 16;
   localparam int ARB_TCL = 8;
   localparam int SPIKE_REJECT_NS = 10;
   localparam int SPIKE_DETECT_NS = 150;
   localparam logic [3:0] FAST_MASK =
      4'(FAST_SAMPLE_TCL * TCL_NS / CLK_NS - 1);
   localparam logic [3:0] STD_MASK =
      4'(STD_SAMPLE_TCL * TCL_NS / CLK_NS - 1);
   localparam logic [3:0] ARB_MASK = 4'(ARB_TCL * TCL_NS / CLK_NS - 1);
   localparam logic [3:0] FILT_CYC =
      4'((SPIKE_REJECT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] FILT_MAX_CYC = 4'(SPIKE_DETECT_NS / CLK_NS);

   // ****************************************
   // register map
   // ****************************************
   localparam logic [15:0] ADDR_EDGE_SEL = 16'hF1C0;
   localparam logic [15:0] ADDR_AUX_CTRL = 16'hF1C4;
   localparam logic [15:0] ADDR_AUX_CAP = 16'hF1C8;
   localparam logic [15:0] ADDR_STATUS = 16'hF1CC;
   localparam logic [15:0] ADDR_MASK = 16'hF1D0;
   localparam logic [15:0] EDGE_SEL_RST = 16'h0000;
   localparam logic [7:0] AUX_CTRL_RST = 8'h00;
   localparam int NUM_FAST = 8;
   localparam int ES_W = 2;
   localparam int AUX_MODE_LSB = 0;
   localparam int AUX_EDGE_LSB = 3;
   localparam int AUX_IE_BIT = 6;
   localparam int AUX_PEC_BIT = 7;
   localparam logic [2:0] AUX_MODE_CAPTURE = 3'h5;
   localparam int STAT_W = 10;
   localparam int STAT_AUX_BIT = 8;
   localparam int STAT_NMI_BIT = 9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0]
   {
      ES_STANDARD = 2'b00,
      ES_RISING = 2'b01,
      ES_FALLING = 2'b10,
      ES_ANY = 2'b11
   } eied_edge_e;

   // low bit selects rising, high bit falling; 00 selects neither
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic old_v,
                                     input logic new_v);
      edge_hit = (sel[0] & new_v & ~old_v) | (sel[1] & ~new_v & old_v);
   endfunction

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

endpackage

/* core/eied_spike_filter.sv */
// one-bit spike suppressor used for inputs seen while asleep
`timescale 1ns/1ps
module eied_spike_filter
   import eied_pkg::*;
#(
   parameter logic INIT = 1'b0
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic din,
   output logic dout
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic out_q;
   logic out_d;

   // ****************************************
   // filter
   // ****************************************
   // a change must persist past the reject time before it is passed on
   always_comb
   begin
      cnt_d = 4'h0;
      out_d = out_q;
      if (din != out_q)
      begin
         if (cnt_q >= FILT_CYC)
            out_d = din;
         else
            cnt_d = cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_q <= 4'h0;
         out_q <= INIT;
      end
      else
      begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign dout = out_q;

endmodule

/* core/eied_top.sv */
// external interrupt edge detection with axi4-lite register access
//
// Contract
// RULE1: fast inputs sampled every two clock phases
// RULE2: standard inputs sampled every sixteen phases
// RULE3: event arbitration only every eight phases
// RULE4: edge field 00 off, 01 rise, 10 fall, 11 both
// RULE5: eight two-bit edge fields, seven topmost
// RULE6: detection leaves pin main function untouched
// RULE7: each request uses its own source line
// RULE8: software sets interrupt pins as inputs
// RULE9: aux pin interrupts only in capture mode
// RULE10: aux edge field low bits pick transitions
// RULE11: aux transition copies core timer count
// RULE12: enabled aux flag raises event or interrupt
// RULE13: sleep uses clockless-style edge capture path
// RULE14: sleep filters spikes on fast and nmi
// RULE15: compare new sample with old per source
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module eied_top
   import eied_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [15:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [15:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic SLEEP,
   input wire logic [7:0] FAST_IN,
   input wire logic NMI_N,
   input wire logic AUX_TIMER_IN,
   input wire logic [15:0] CORE_TIMER,
   output logic [7:0] FAST_REQ,
   output logic AUX_IRQ_REQ,
   output logic AUX_PEC_REQ,
   output logic NMI_TRAP,
   output logic IRQ
);

   // ****************************************
   // bus slave
   // ****************************************
   logic [15:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, wmask_q, wmask_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_wr;
   logic [31:0] wbits;

   // event-side state, declared early because reads see it
   logic [15:0] edge_sel_q, edge_sel_d, cap_q, cap_d;
   logic [7:0] aux_ctrl_q, aux_ctrl_d;
   logic [STAT_W-1:0] status_q, status_d, mask_q, mask_d;

   assign do_wr = aw_have_q & w_have_q & ~bvalid_q;
   assign wbits = wdata_q & wmask_q;

   always_comb
   begin
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wmask_d = wmask_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (AWVALID && awready_q)
      begin
         awaddr_d = AWADDR;
         aw_have_d = 1'b1;
      end
      if (WVALID && wready_q)
      begin
         wdata_d = WDATA;
         wmask_d = strb_mask(WSTRB);
         w_have_d = 1'b1;
      end
      if (do_wr)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         case (awaddr_q)
            ADDR_EDGE_SEL, ADDR_AUX_CTRL, ADDR_AUX_CAP,
            ADDR_STATUS, ADDR_MASK: bresp_d = RESP_OKAY;
            default: bresp_d = RESP_DECERR;
         endcase
      end
      else if (bvalid_q && BREADY)
         bvalid_d = 1'b0;
      if (ARVALID && arready_q)
      begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         case (ARADDR)
            ADDR_EDGE_SEL: rdata_d = {16'h0000, edge_sel_q};
            ADDR_AUX_CTRL: rdata_d = {24'h000000, aux_ctrl_q};
            ADDR_AUX_CAP: rdata_d = {16'h0000, cap_q};
            ADDR_STATUS: rdata_d = {22'h0, status_q};
            ADDR_MASK: rdata_d = {22'h0, mask_q};
            default:
            begin
               rdata_d = 32'h00000000;
               rresp_d = RESP_DECERR;
            end
         endcase
      end
      else if (rvalid_q && RREADY)
         rvalid_d = 1'b0;
      // one write and one read in flight at a time
      awready_d = ~aw_have_d & ~bvalid_d;
      wready_d = ~w_have_d & ~bvalid_d;
      arready_d = ~rvalid_d;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         awaddr_q <= 16'h0000;
         wdata_q <= 32'h00000000;
         wmask_q <= 32'h00000000;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wmask_q <= wmask_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // sleep spike filters
   // ****************************************
   logic [NUM_FAST:0] filt_in, filt_out;
   assign filt_in = {NMI_N, FAST_IN};

   // RULE14: filter fast and nmi
   generate
      for (genvar i = 0; i <= NUM_FAST; i++)
      begin : g_filt
         eied_spike_filter #(.INIT(i == NUM_FAST)) u_filt
         (
            .clk(CLK),
            .srst(SRST),
            .din(filt_in[i]),
            .dout(filt_out[i])
         );
      end
   endgenerate

   // ****************************************
   // edge detection and arbitration
   // ****************************************
   logic [3:0] phase_q, phase_d;
   logic fast_slot, std_slot, arb_slot, take;
   logic [NUM_FAST:0] src, smp_q, smp_d, pend_q, pend_d;
   logic aux_smp_q, aux_smp_d, aux_pend_q, aux_pend_d, aux_hit;
   logic [7:0] fast_req_q, fast_req_d;
   logic aux_irq_q, aux_irq_d, aux_pec_q, aux_pec_d;
   logic nmi_trap_q, nmi_trap_d, irq_q, irq_d;
   logic [STAT_W-1:0] set_vec, clr_vec;

   // RULE1: fast sampling slot
   assign fast_slot = (phase_q & FAST_MASK) == FAST_MASK;
   // RULE2: standard scan slot
   assign std_slot = (phase_q & STD_MASK) == STD_MASK;
   // RULE3: arbitration slot
   assign arb_slot = (phase_q & ARB_MASK) == ARB_MASK;
   // RULE13: asleep, take every filtered capture
   assign take = SLEEP | fast_slot;
   assign src = SLEEP ? filt_out : filt_in;
   // RULE9: aux pin counts only in capture mode
   assign aux_hit = std_slot &&
      aux_ctrl_q[AUX_MODE_LSB +: 3] == AUX_MODE_CAPTURE &&
      // RULE10: top bit of edge field ignored
      edge_hit(aux_ctrl_q[AUX_EDGE_LSB +: 2], aux_smp_q, AUX_TIMER_IN);

   // RULE6: pins are only observed, never driven or masked
   always_comb
   begin
      phase_d = phase_q + 4'h1;
      smp_d = take ? src : smp_q;
      aux_smp_d = std_slot ? AUX_TIMER_IN : aux_smp_q;
      // a new edge in the transfer cycle stays pending
      pend_d = arb_slot ? '0 : pend_q;
      for (int i = 0; i < NUM_FAST; i++)
      begin
         // RULE15: new sample against old one
         // RULE4: field decode per source
         if (take && edge_hit(edge_sel_q[i*ES_W +: ES_W], smp_q[i], src[i]))
            pend_d[i] = 1'b1;
      end
      if (take && smp_q[NUM_FAST] && !src[NUM_FAST])
         pend_d[NUM_FAST] = 1'b1;
      aux_pend_d = (aux_pend_q & ~arb_slot) | aux_hit;
      // RULE11: capture core timer on aux edge
      cap_d = aux_hit ? CORE_TIMER : cap_q;
      // RULE7: each source raises its own line
      fast_req_d = arb_slot ? pend_q[NUM_FAST-1:0] : 8'h00;
      nmi_trap_d = arb_slot & pend_q[NUM_FAST];
      // RULE12: enabled aux flag picks event or interrupt
      aux_pec_d = arb_slot & aux_pend_q & aux_ctrl_q[AUX_IE_BIT] &
                  aux_ctrl_q[AUX_PEC_BIT];
      aux_irq_d = arb_slot & aux_pend_q & aux_ctrl_q[AUX_IE_BIT] &
                  ~aux_ctrl_q[AUX_PEC_BIT];
      set_vec = arb_slot ? {pend_q[NUM_FAST], aux_pend_q,
                            pend_q[NUM_FAST-1:0]} : '0;
      clr_vec = (do_wr && awaddr_q == ADDR_STATUS) ?
                wbits[STAT_W-1:0] : '0;
      // set beats a write-one-to-clear in the same cycle
      status_d = (status_q & ~clr_vec) | set_vec;
      mask_d = mask_q;
      edge_sel_d = edge_sel_q;
      aux_ctrl_d = aux_ctrl_q;
      if (do_wr)
      begin
         // RULE5: eight fields, source seven on top
         if (awaddr_q == ADDR_EDGE_SEL)
            edge_sel_d = (edge_sel_q & ~wmask_q[15:0]) | wbits[15:0];
         if (awaddr_q == ADDR_AUX_CTRL)
            aux_ctrl_d = (aux_ctrl_q & ~wmask_q[7:0]) | wbits[7:0];
         if (awaddr_q == ADDR_MASK)
            mask_d = (mask_q & ~wmask_q[STAT_W-1:0]) | wbits[STAT_W-1:0];
      end
      irq_d = |(status_q & mask_q);
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         phase_q <= 4'h0;
         smp_q <= {1'b1, 8'h00};
         pend_q <= '0;
         aux_smp_q <= 1'b0;
         aux_pend_q <= 1'b0;
         cap_q <= 16'h0000;
         fast_req_q <= 8'h00;
         nmi_trap_q <= 1'b0;
         aux_pec_q <= 1'b0;
         aux_irq_q <= 1'b0;
         status_q <= '0;
         mask_q <= '0;
         edge_sel_q <= EDGE_SEL_RST;
         aux_ctrl_q <= AUX_CTRL_RST;
         irq_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         smp_q <= smp_d;
         pend_q <= pend_d;
         aux_smp_q <= aux_smp_d;
         aux_pend_q <= aux_pend_d;
         cap_q <= cap_d;
         fast_req_q <= fast_req_d;
         nmi_trap_q <= nmi_trap_d;
         aux_pec_q <= aux_pec_d;
         aux_irq_q <= aux_irq_d;
         status_q <= status_d;
         mask_q <= mask_d;
         edge_sel_q <= edge_sel_d;
         aux_ctrl_q <= aux_ctrl_d;
         irq_q <= irq_d;
      end
   end

   assign AWREADY = awready_q;
   assign WREADY = wready_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;
   assign FAST_REQ = fast_req_q;
   assign AUX_IRQ_REQ = aux_irq_q;
   assign AUX_PEC_REQ = aux_pec_q;
   assign NMI_TRAP = nmi_trap_q;
   assign IRQ = irq_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   sequence s_aux_edge;
      aux_hit ##1 (aux_pend_q && cap_q == $past(CORE_TIMER));
   endsequence
   sequence s_aux_serve;
      arb_slot && aux_pend_q && aux_ctrl_q[AUX_IE_BIT] ##1
         (AUX_IRQ_REQ != AUX_PEC_REQ) && status_q[STAT_AUX_BIT];
   endsequence

   property p_fast_hold;
      !SLEEP && !fast_slot |=> $stable(smp_q);
   endproperty
   property p_std_hold;
      !std_slot |=> $stable(aux_smp_q);
   endproperty
   property p_arb_only;
      (|FAST_REQ) || NMI_TRAP |-> $past(arb_slot);
   endproperty
   property p_rise_detect;
      take && edge_sel_q[1:0] == ES_RISING && !smp_q[0] && src[0]
         |=> pend_q[0] || FAST_REQ[0];
   endproperty
   property p_standard_quiet;
      edge_sel_q[1:0] == ES_STANDARD && !pend_q[0] |=> !pend_q[0];
   endproperty
   property p_set_wins;
      arb_slot && pend_q[0] |=> status_q[0] && FAST_REQ[0];
   endproperty
   property p_aux_capture;
      aux_hit |-> s_aux_edge;
   endproperty
   property p_aux_mode;
      aux_ctrl_q[AUX_MODE_LSB +: 3] != AUX_MODE_CAPTURE && !aux_pend_q
         |=> !aux_pend_q;
   endproperty
   property p_aux_serve;
      arb_slot && aux_pend_q && aux_ctrl_q[AUX_IE_BIT] |-> s_aux_serve;
   endproperty
   property p_irq;
      |(status_q & mask_q) |=> IRQ;
   endproperty

   a_fast_hold: assert property (p_fast_hold) // RULE1
      else $error("fast sample moved off its slot");
   a_std_hold: assert property (p_std_hold) // RULE2
      else $error("standard sample moved off its slot");
   a_arb_only: assert property (p_arb_only) // RULE3
      else $error("request issued outside arbitration slot");
   a_rise_detect: assert property (p_rise_detect) // RULE15
      else $error("rising edge not flagged");
   a_standard_quiet: assert property (p_standard_quiet) // RULE4
      else $error("standard mode raised a fast request");
   a_set_wins: assert property (p_set_wins) // RULE7
      else $error("pending source not raised on its line");
   a_aux_capture: assert property (p_aux_capture) // RULE11
      else $error("aux edge did not capture core timer");
   a_aux_mode: assert property (p_aux_mode) // RULE9
      else $error("aux request outside capture mode");
   a_aux_serve: assert property (p_aux_serve) // RULE12
      else $error("enabled aux flag gave no single request");
   a_irq: assert property (p_irq) // RULE7
      else $error("unmasked status did not raise irq");

endmodule

/* verif/eied_event_model.sv */
// event source and request sink model facing the edge-detect block
`timescale 1ns/1ps
module eied_event_model
   import eied_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic clr,
   input wire logic [7:0] fast_lvl,
   input wire logic nmi_lvl,
   input wire logic aux_lvl,
   input wire logic [15:0] tmr_val,
   input wire logic [7:0] fast_req,
   input wire logic aux_irq,
   input wire logic aux_pec,
   input wire logic nmi_trap,
   output logic [7:0] fast_in,
   output logic nmi_n,
   output logic aux_in,
   output logic [15:0] core_tmr,
   output int n_fast,
   output int n_aux,
   output int n_pec,
   output int n_nmi,
   output logic [7:0] last_fast,
   output logic bad_gap
);
   int cyc;
   int last_c;
   logic any;
   // pins driven only into the block
   assign fast_in = fast_lvl;
   assign nmi_n = ~nmi_lvl;
   assign aux_in = aux_lvl;
   // timer count held steady so capture is exact
   assign core_tmr = tmr_val;
   assign any = |{fast_req, aux_irq, aux_pec, nmi_trap};
   // ****************************************
   // arbiter side: count requests, watch the slot grid
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cyc <= 0;
         last_c <= -1;
         bad_gap <= 1'b0;
         last_fast <= 8'h00;
      end
      else
      begin
         cyc <= cyc + 1;
         if (any)
            last_c <= cyc;
         // requests only on the eight-cycle grid
         if (any && last_c >= 0 && (cyc - last_c) % 8 != 0)
            bad_gap <= 1'b1;
         if (fast_req != 8'h00)
            last_fast <= fast_req;
      end
      if (srst || clr)
      begin
         n_fast <= 0;
         n_aux <= 0;
         n_pec <= 0;
         n_nmi <= 0;
      end
      else
      begin
         n_fast <= n_fast + $countones(fast_req);
         n_aux <= n_aux + int'(aux_irq);
         n_pec <= n_pec + int'(aux_pec);
         n_nmi <= n_nmi + int'(nmi_trap);
      end
   end
endmodule

/* verif/eied_top_tb.sv */
// self-checking bench for the edge-detect block
`timescale 1ns/1ps
module eied_top_tb;
   import eied_pkg::*;
   logic CLK = 1'b0, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID;
   logic BREADY, ARVALID, ARREADY, RVALID, RREADY, SLEEP, NMI_N;
   logic AUX_TIMER_IN, AUX_IRQ_REQ, AUX_PEC_REQ, NMI_TRAP, IRQ;
   logic [15:0] AWADDR, ARADDR, CORE_TIMER, tmr_val;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic [7:0] FAST_IN, FAST_REQ, fast_lvl, last_fast;
   logic clr, nmi_lvl, aux_lvl, bad_gap;
   int n_fast, n_aux, n_pec, n_nmi, lat, miscompares, checks_done;
   always #5 CLK = ~CLK;
   eied_top u_dut (.CLK(CLK), .SRST(SRST), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .SLEEP(SLEEP), .FAST_IN(FAST_IN), .NMI_N(NMI_N),
      .AUX_TIMER_IN(AUX_TIMER_IN), .CORE_TIMER(CORE_TIMER),
      .FAST_REQ(FAST_REQ), .AUX_IRQ_REQ(AUX_IRQ_REQ),
      .AUX_PEC_REQ(AUX_PEC_REQ), .NMI_TRAP(NMI_TRAP), .IRQ(IRQ));
   eied_event_model u_model (.clk(CLK), .srst(SRST), .clr(clr),
      .fast_lvl(fast_lvl), .nmi_lvl(nmi_lvl), .aux_lvl(aux_lvl),
      .tmr_val(tmr_val), .fast_req(FAST_REQ), .aux_irq(AUX_IRQ_REQ),
      .aux_pec(AUX_PEC_REQ), .nmi_trap(NMI_TRAP), .fast_in(FAST_IN),
      .nmi_n(NMI_N), .aux_in(AUX_TIMER_IN), .core_tmr(CORE_TIMER),
      .n_fast(n_fast), .n_aux(n_aux), .n_pec(n_pec), .n_nmi(n_nmi),
      .last_fast(last_fast), .bad_gap(bad_gap));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // a bus answer that never comes ends the run
   task automatic tmo(input int n);
      if (n >= 40)
      begin
         chk("bus_answer", 32'h1, 32'h0);
         end_sim();
      end
   endtask
   // address and data are released one by one, in whatever order taken
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      bit aw_on;
      bit w_on;
      n = 0;
      aw_on = 1'b1;
      w_on = 1'b1;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
         if (aw_on && AWREADY === 1'b1)
         begin
            AWVALID <= 1'b0;
            aw_on = 1'b0;
         end
         if (w_on && WREADY === 1'b1)
         begin
            WVALID <= 1'b0;
            w_on = 1'b0;
         end
      end
      while ((aw_on || w_on || BVALID !== 1'b1) && n < 40);
      tmo(n);
      BREADY <= 1'b0;
      chk("bresp", 32'(er), 32'(BRESP));
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
         if (ARREADY === 1'b1)
            ARVALID <= 1'b0;
      end
      while (RVALID !== 1'b1 && n < 40);
      tmo(n);
      RREADY <= 1'b0;
      chk("rdata", e, RDATA);
      chk("rresp", 32'(er), 32'(RRESP));
   endtask
   task automatic zap();
      @(posedge CLK);
      clr <= 1'b1;
      @(posedge CLK);
      clr <= 1'b0;
   endtask
   // window covers a standard scan plus one arbitration slot
   task automatic settle();
      lat = 99;
      for (int k = 1; k <= 32; k++)
      begin
         @(posedge CLK);
         if (lat == 99 && n_fast + n_aux + n_pec + n_nmi != 0)
            lat = k;
      end
   endtask
   task automatic edge_run(input int i, input logic [1:0] s);
      wr(ADDR_EDGE_SEL, 32'(s) << (2 * i), RESP_OKAY);
      zap();
      fast_lvl[i] <= 1'b1;
      settle();
      chk("rise_req", 32'(s[0]), 32'(n_fast));
      if (s[0])
         chk("fast_lat", 32'h1, 32'(lat <= 13));
      zap();
      fast_lvl[i] <= 1'b0;
      settle();
      chk("fall_req", 32'(s[1]), 32'(n_fast));
      if (s != 2'b00)
         chk("source", 32'h1 << i, 32'(last_fast));
   endtask
   task automatic spike(input int w, input logic [31:0] e);
      zap();
      fast_lvl[1] <= 1'b1;
      nmi_lvl <= 1'b1;
      repeat (w) @(posedge CLK);
      fast_lvl[1] <= 1'b0;
      nmi_lvl <= 1'b0;
      settle();
      chk("sleep_fast", e, 32'(n_fast));
      chk("sleep_nmi", e, 32'(n_nmi));
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {SRST, clr, SLEEP, AWVALID, WVALID, BREADY} <= 6'h20;
      {ARVALID, RREADY, nmi_lvl, aux_lvl} <= 4'h0;
      {AWADDR, ARADDR, WDATA, tmr_val} <= '0;
      WSTRB <= 4'hF;
      fast_lvl <= 8'h00;
      repeat (12) @(posedge CLK);
      SRST <= 1'b0;
      rd(ADDR_EDGE_SEL, 32'(EDGE_SEL_RST), RESP_OKAY);
      wr(ADDR_EDGE_SEL, 32'hFFFFA5C3, RESP_OKAY);
      rd(ADDR_EDGE_SEL, 32'h0000A5C3, RESP_OKAY);
      WSTRB <= 4'h1;
      wr(ADDR_EDGE_SEL, 32'h0000FF3C, RESP_OKAY);
      WSTRB <= 4'hF;
      rd(ADDR_EDGE_SEL, 32'h0000A53C, RESP_OKAY);
      wr(16'hF1E0, 32'h1, RESP_DECERR);
      rd(16'hF1E0, 32'h0, RESP_DECERR);
      $display("test registers done");
      for (int i = 0; i < 8; i += 7)
         for (int s = 0; s < 4; s++)
            edge_run(i, 2'(s));
      $display("test edges done");
      wr(ADDR_STATUS, 32'h3FF, RESP_OKAY);
      wr(ADDR_MASK, 32'h0, RESP_OKAY);
      wr(ADDR_EDGE_SEL, 32'h1, RESP_OKAY);
      fast_lvl[0] <= 1'b1;
      settle();
      chk("irq_masked", 32'h0, 32'(IRQ));
      rd(ADDR_STATUS, 32'h1, RESP_OKAY);
      wr(ADDR_MASK, 32'h1, RESP_OKAY);
      repeat (3) @(posedge CLK);
      chk("irq_on", 32'h1, 32'(IRQ));
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      repeat (3) @(posedge CLK);
      chk("irq_off", 32'h0, 32'(IRQ));
      zap();
      nmi_lvl <= 1'b1;
      settle();
      chk("nmi", 32'h1, 32'(n_nmi));
      rd(ADDR_STATUS, 32'h200, RESP_OKAY);
      nmi_lvl <= 1'b0;
      $display("test interrupts done");
      for (int e = 5; e <= 7; e++)
      begin
         wr(ADDR_AUX_CTRL, 32'h45 | 32'(e << 3), RESP_OKAY);
         zap();
         tmr_val <= 16'(16'h1100 + e);
         aux_lvl <= 1'b1;
         settle();
         chk("aux_rise", 32'(e & 1), 32'(n_aux));
         if (e != 6)
            chk("aux_lat", 32'h1, 32'(lat <= 27));
         zap();
         tmr_val <= 16'(16'h2200 + e);
         aux_lvl <= 1'b0;
         settle();
         chk("aux_fall", 32'((e >> 1) & 1), 32'(n_aux));
         rd(ADDR_AUX_CAP, 32'(e[1] ? 16'h2200 + e : 16'h1100 + e),
            RESP_OKAY);
      end
      wr(ADDR_AUX_CTRL, 32'h58, RESP_OKAY);
      zap();
      aux_lvl <= 1'b1;
      settle();
      chk("aux_nomode", 32'h0, 32'(n_aux));
      wr(ADDR_AUX_CTRL, 32'hD5, RESP_OKAY);
      zap();
      tmr_val <= 16'h3300;
      aux_lvl <= 1'b0;
      settle();
      chk("aux_pec", 32'h1, 32'(n_pec));
      chk("aux_irq", 32'h0, 32'(n_aux));
      wr(ADDR_AUX_CAP, 32'h0, RESP_OKAY);
      rd(ADDR_AUX_CAP, 32'h3300, RESP_OKAY);
      $display("test aux timer done");
      SLEEP <= 1'b1;
      wr(ADDR_EDGE_SEL, 32'h4, RESP_OKAY);
      spike(1, 32'h0);
      spike(15, 32'h1);
      SLEEP <= 1'b0;
      chk("slot_grid", 32'h0, 32'(bad_gap));
      $display("test sleep done");
      end_sim();
   end
endmodule
